// ### shared/bad_pkg.sv
// Package of the bank address decoder: bus widths, register map, reset values.
// Assumes a 32-bit AXI4-Lite register bus and an 18-bit active-low system address bus.
package bad_pkg;

  // System bus geometry
  localparam int unsigned ADDR_BITS   = 18;
  localparam int unsigned BANK_MSB    = 17;
  localparam int unsigned BANK_LSB    = 14;
  localparam int unsigned WORD_MSB    = 13;
  localparam int unsigned WORD_LSB    = 1;
  localparam int unsigned WORD_W      = WORD_MSB - WORD_LSB + 1;
  localparam int unsigned BANK_W      = BANK_MSB - BANK_LSB + 1;
  localparam int unsigned CMP_W       = BANK_W + 2;
  localparam int unsigned CTL_READ_BIT = 1;

  // Register bus geometry
  localparam int unsigned AXI_ADDR_W  = 4;
  localparam int unsigned AXI_DATA_W  = 32;
  localparam int unsigned CNT_W       = 16;

  // Register byte offsets
  localparam logic [AXI_ADDR_W-1:0] OFS_CTRL     = 4'h0;
  localparam logic [AXI_ADDR_W-1:0] OFS_STATUS   = 4'h4;
  localparam logic [AXI_ADDR_W-1:0] OFS_SEL_CNT  = 4'h8;
  localparam logic [AXI_ADDR_W-1:0] OFS_LAST_ADR = 4'hC;

  // Control register fields
  localparam int unsigned CTRL_DEC_EN_BIT = 0;
  localparam int unsigned CTRL_CNT_CLR_BIT = 1;
  localparam logic        CTRL_DEC_EN_RST = 1'b1;

  // Status register fields
  localparam int unsigned ST_SEL_BIT      = 0;
  localparam int unsigned ST_TEST_BIT     = 1;
  localparam int unsigned ST_RO_BIT       = 2;
  localparam int unsigned ST_UNUSED_BIT   = 3;
  localparam int unsigned ST_BANK_LSB     = 4;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : bad_pkg

// ### logic/bad_compare.sv
// Per-bit equality comparators joined as one wired-AND match.
// Assumes both vectors are in active-high logical form.
`timescale 1ns/1ps
module bad_compare #(
  parameter int unsigned WIDTH = 6
) (
  // Compared vectors
  input  wire logic [WIDTH-1:0] received,
  input  wire logic [WIDTH-1:0] expected,
  // Result
  output wire logic             all_match
);

  logic [WIDTH-1:0] bit_eq;

  // One equality gate per bit, like an open-collector comparator
  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi++) begin : g_cmp
      assign bit_eq[gi] = ~(received[gi] ^ expected[gi]);
    end
  endgenerate

  // Common node is high only if no gate pulls it low
  assign all_match = &bit_eq;

  // Refuse a comparator with no bits while elaborating, not at run time
  if (WIDTH < 1) begin : g_bad_width
    $error("bad_compare: WIDTH must be at least 1");
  end

endmodule : bad_compare

// ### logic/bad_decoder.sv
// Bank address decoder: strap-set bank match on the system bus, plus AXI4-Lite view.
// Assumes synchronous inputs on aclk and straps that are static during use.
//
// How it works
// - select decoded from address bits 17..14
// - installed strap wants 0, removed wants 1
// - select only when every comparator matches
// - bus lines low-true, inside logic high-true
// - power-low line joins the same comparison
// - unused comparator tied constant, strap installed
// - four straps pick one of sixteen banks
// - missing test strap means non-operational
// - read-only strap forces read on selected transfers
// - bits 13..1 word, bit 0 byte
`timescale 1ns/1ps
module bad_decoder
  import bad_pkg::*;
(
  // Clock and reset
  input  wire logic                       aclk,
  input  wire logic                       aresetn,
  // System bus, active low
  input  wire logic [bad_pkg::ADDR_BITS-1:0] bus_addr_n,
  input  wire logic                       bus_dc_lo_n,
  input  wire logic [1:0]                 bus_ctl_n,
  // Straps, 1 = installed
  input  wire logic                       bank_strap_bit3,
  input  wire logic                       bank_strap_bit2,
  input  wire logic                       bank_strap_bit1,
  input  wire logic                       bank_strap_bit0,
  input  wire logic                       unused_slot_strap,
  input  wire logic                       test_strap,
  input  wire logic                       read_only_strap,
  // Memory control side
  output wire logic                       bank_sel,
  output logic [bad_pkg::WORD_W-1:0]      word_index,
  output logic                            byte_sel,
  output logic                            xfer_read,
  output logic                            test_mode,
  // AXI4-Lite write address
  input  wire logic                       s_axi_awvalid,
  output logic                            s_axi_awready,
  input  wire logic [bad_pkg::AXI_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic [2:0]                 s_axi_awprot,
  // AXI4-Lite write data
  input  wire logic                       s_axi_wvalid,
  output logic                            s_axi_wready,
  input  wire logic [bad_pkg::AXI_DATA_W-1:0] s_axi_wdata,
  input  wire logic [3:0]                 s_axi_wstrb,
  // AXI4-Lite write response
  output logic                            s_axi_bvalid,
  input  wire logic                       s_axi_bready,
  output logic [1:0]                      s_axi_bresp,
  // AXI4-Lite read address
  input  wire logic                       s_axi_arvalid,
  output logic                            s_axi_arready,
  input  wire logic [bad_pkg::AXI_ADDR_W-1:0] s_axi_araddr,
  input  wire logic [2:0]                 s_axi_arprot,
  // AXI4-Lite read data
  output logic                            s_axi_rvalid,
  input  wire logic                       s_axi_rready,
  output logic [bad_pkg::AXI_DATA_W-1:0]  s_axi_rdata,
  output logic [1:0]                      s_axi_rresp
);

  import bad_pkg::*;

  // All state of the block
  typedef struct packed {
    logic                  awready;
    logic                  wready;
    logic                  aw_got;
    logic                  w_got;
    logic [AXI_ADDR_W-1:0] aw_addr;
    logic [AXI_DATA_W-1:0] w_data;
    logic [3:0]            w_strb;
    logic                  bvalid;
    logic [1:0]            bresp;
    logic                  arready;
    logic                  rvalid;
    logic [AXI_DATA_W-1:0] rdata;
    logic [1:0]            rresp;
    logic                  dec_en;
    logic [CNT_W-1:0]      sel_cnt;
    logic                  sel_prev;
    logic [ADDR_BITS-1:0]  last_addr;
    logic [WORD_W-1:0]     word_index;
    logic                  byte_sel;
    logic                  xfer_read;
    logic                  test_mode;
  } bad_state_t;

  bad_state_t state_ff;
  bad_state_t nxt_state;

  logic [ADDR_BITS-1:0] addr_log;
  logic [BANK_W-1:0]    bank_no;
  logic [CMP_W-1:0]     cmp_rx;
  logic [CMP_W-1:0]     cmp_exp;
  logic                 cmp_match;
  logic                 sel_now;
  logic                 ctl_c1;
  logic                 do_write;
  logic                 aw_hs;
  logic                 w_hs;
  logic [AXI_DATA_W-1:0] rd_word;
  logic [1:0]           rd_resp;

  // Bus lines are low-true; flip once at the edge of the block
  assign addr_log = ~bus_addr_n;
  assign ctl_c1   = ~bus_ctl_n[CTL_READ_BIT];

  // Installed strap means the bank bit must be logical 0
  assign bank_no = ~{bank_strap_bit3, bank_strap_bit2,
                     bank_strap_bit1, bank_strap_bit0};

  // Comparator inputs: unused slot, power-low, then bank bits 17..14
  assign cmp_rx  = {1'b0, ~bus_dc_lo_n, addr_log[BANK_MSB:BANK_LSB]};
  assign cmp_exp = {~unused_slot_strap, 1'b0, bank_no};

  bad_compare #(
    .WIDTH(CMP_W)
  ) u_cmp (
    .received (cmp_rx),
    .expected (cmp_exp),
    .all_match(cmp_match)
  );

  // No flop here: select follows the bus within gate delay
  assign sel_now  = cmp_match & test_strap & state_ff.dec_en;
  assign bank_sel = sel_now;

  // Handshakes seen this cycle
  assign aw_hs    = s_axi_awvalid & state_ff.awready;
  assign w_hs     = s_axi_wvalid & state_ff.wready;
  assign do_write = state_ff.aw_got & state_ff.w_got & ~state_ff.bvalid;

  // Read mux; unmapped offsets answer zero with an error
  always_comb begin
    rd_word = '0;
    rd_resp = RESP_OKAY;
    case (s_axi_araddr)
      OFS_CTRL: begin
        rd_word[CTRL_DEC_EN_BIT] = state_ff.dec_en;
      end
      OFS_STATUS: begin
        rd_word[ST_SEL_BIT]    = sel_now;
        rd_word[ST_TEST_BIT]   = state_ff.test_mode;
        rd_word[ST_RO_BIT]     = read_only_strap;
        rd_word[ST_UNUSED_BIT] = unused_slot_strap;
        rd_word[ST_BANK_LSB +: BANK_W] = bank_no;
      end
      OFS_SEL_CNT: begin
        rd_word[CNT_W-1:0] = state_ff.sel_cnt;
      end
      OFS_LAST_ADR: begin
        rd_word[ADDR_BITS-1:0] = state_ff.last_addr;
      end
      default: begin
        rd_resp = RESP_SLVERR;
      end
    endcase
  end

  // Next-state logic for bus slave and decode side
  always_comb begin
    nxt_state = state_ff;

    // Write address and data are taken in either order
    if (aw_hs) begin
      nxt_state.aw_got  = 1'b1;
      nxt_state.aw_addr = s_axi_awaddr;
    end
    if (w_hs) begin
      nxt_state.w_got  = 1'b1;
      nxt_state.w_data = s_axi_wdata;
      nxt_state.w_strb = s_axi_wstrb;
    end

    // Select hit counter; a hit in the clear cycle still counts
    if (sel_now & ~state_ff.sel_prev) begin
      nxt_state.sel_cnt   = state_ff.sel_cnt + 1'b1;
      nxt_state.last_addr = addr_log;
    end
    nxt_state.sel_prev = sel_now;

    // Register write once both halves are held
    if (do_write) begin
      nxt_state.aw_got = 1'b0;
      nxt_state.w_got  = 1'b0;
      nxt_state.bvalid = 1'b1;
      nxt_state.bresp  = RESP_OKAY;
      case (state_ff.aw_addr)
        OFS_CTRL: begin
          if (state_ff.w_strb[0]) begin
            nxt_state.dec_en = state_ff.w_data[CTRL_DEC_EN_BIT];
            if (state_ff.w_data[CTRL_CNT_CLR_BIT]) begin
              nxt_state.sel_cnt = (sel_now & ~state_ff.sel_prev) ? CNT_W'(1) : '0;
            end
          end
        end
        OFS_STATUS, OFS_SEL_CNT, OFS_LAST_ADR: begin
          nxt_state.bresp = RESP_OKAY;
        end
        default: begin
          nxt_state.bresp = RESP_SLVERR;
        end
      endcase
    end
    if (state_ff.bvalid & s_axi_bready) begin
      nxt_state.bvalid = 1'b0;
    end
    nxt_state.awready = ~nxt_state.aw_got & ~nxt_state.bvalid;
    nxt_state.wready  = ~nxt_state.w_got & ~nxt_state.bvalid;

    // Read channel, one outstanding
    if (s_axi_arvalid & state_ff.arready) begin
      nxt_state.rvalid = 1'b1;
      nxt_state.rdata  = rd_word;
      nxt_state.rresp  = rd_resp;
    end else if (state_ff.rvalid & s_axi_rready) begin
      nxt_state.rvalid = 1'b0;
    end
    nxt_state.arready = ~nxt_state.rvalid;

    // Word and byte address for the array side
    nxt_state.word_index = addr_log[WORD_MSB:WORD_LSB];
    nxt_state.byte_sel   = addr_log[0];
    // Read-only strap ignores the control lines
    nxt_state.xfer_read  = read_only_strap | ~ctl_c1;
    nxt_state.test_mode  = ~test_strap;
  end

  // State register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_ff        <= '0;
      state_ff.dec_en <= CTRL_DEC_EN_RST;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Outputs straight from flops
  assign word_index    = state_ff.word_index;
  assign byte_sel      = state_ff.byte_sel;
  assign xfer_read     = state_ff.xfer_read;
  assign test_mode     = state_ff.test_mode;
  assign s_axi_awready = state_ff.awready;
  assign s_axi_wready  = state_ff.wready;
  assign s_axi_bvalid  = state_ff.bvalid;
  assign s_axi_bresp   = state_ff.bresp;
  assign s_axi_arready = state_ff.arready;
  assign s_axi_rvalid  = state_ff.rvalid;
  assign s_axi_rdata   = state_ff.rdata;
  assign s_axi_rresp   = state_ff.rresp;

endmodule : bad_decoder

// ### test/bad_bus_master_model.sv
// Far-side bus master: logical address and control onto low-true lines.
// Assumes the bench changes the logical inputs just after a rising edge.
`timescale 1ns/1ps
module bad_bus_master_model (
  // Logical side
  input  wire logic [17:0] addr,
  input  wire logic        dc_lo,
  input  wire logic        wr,
  // Bus side
  output wire logic [17:0] bus_addr_n,
  output wire logic        bus_dc_lo_n,
  output wire logic [1:0]  bus_ctl_n
);
  // Low level carries logical 1 on every line
  assign bus_addr_n  = ~addr;
  assign bus_dc_lo_n = ~dc_lo;
  assign bus_ctl_n   = ~{wr, 1'h0};
endmodule // bad_bus_master_model

// ### test/bad_decoder_props.sv
// Port checker of the bank address decoder.
// Assumes the bind below reaches every decoder instance.
`timescale 1ns/1ps
module bad_decoder_props (
  // Clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // Bus and straps
  input wire logic [17:0] bus_addr_n,
  input wire logic        bus_dc_lo_n,
  input wire logic [1:0]  bus_ctl_n,
  input wire logic        bank_strap_bit3,
  input wire logic        bank_strap_bit2,
  input wire logic        bank_strap_bit1,
  input wire logic        bank_strap_bit0,
  input wire logic        unused_slot_strap,
  input wire logic        test_strap,
  input wire logic        read_only_strap,
  // Decoder outputs
  input wire logic        bank_sel,
  input wire logic [12:0] word_index,
  input wire logic        byte_sel,
  input wire logic        xfer_read,
  input wire logic        test_mode
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Strap low-true level equals the bus level when matched
  a_sel_bank: assert property (bank_sel |-> bus_addr_n[17:14] ==
    {bank_strap_bit3, bank_strap_bit2, bank_strap_bit1, bank_strap_bit0})
    else $error("select outside configured bank");
  a_sel_power: assert property (bank_sel |-> bus_dc_lo_n)
    else $error("select during power low");
  a_sel_unused: assert property (bank_sel |-> unused_slot_strap)
    else $error("select without unused slot strap");
  a_sel_test: assert property (!test_strap |-> !bank_sel)
    else $error("select in test configuration");
  a_test_flag: assert property ($past(aresetn) |-> test_mode == !$past(test_strap))
    else $error("test flag wrong");
  a_ro_read: assert property ($past(aresetn) && $past(read_only_strap) |-> xfer_read)
    else $error("read-only strap not forcing read");
  a_ctl_read: assert property ($past(aresetn) && !$past(read_only_strap) |->
    xfer_read == $past(bus_ctl_n[1])) else $error("read flag not following control");
  // Word and byte fields trail the bus by one cycle
  a_word_addr: assert property ($past(aresetn) |-> word_index == ~$past(bus_addr_n[13:1])
    && byte_sel == !$past(bus_addr_n[0])) else $error("word or byte field wrong");
endmodule // bad_decoder_props
bind bad_decoder bad_decoder_props i_bad_decoder_props (.aclk, .aresetn, .bus_addr_n,
  .bus_dc_lo_n, .bus_ctl_n, .bank_strap_bit3, .bank_strap_bit2, .bank_strap_bit1,
  .bank_strap_bit0, .unused_slot_strap, .test_strap, .read_only_strap, .bank_sel,
  .word_index, .byte_sel, .xfer_read, .test_mode);

// ### test/bad_decoder_tb_top.sv
// Bench of the bank address decoder: bank decode, straps, register bus.
// Assumes the decoder, checker and bus master model are compiled first.
`timescale 1ns/1ps
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin mismatches++; \
$display("ERROR %0t got %h want %h", $time, a, e); end end
module bad_decoder_tb_top;
  import bad_pkg::*;
  // Bench state
  logic        aclk = '0, aresetn = '0, dc_lo = '0, wr = '0, uns = 1'h1, tst = 1'h1, ro = '0;
  logic        awv = '0, wv = '0, bry = '0, arv = '0, rry = '0;
  logic [17:0] addr = '0;
  logic [3:0]  bank_no = '0, awaddr = '0, araddr = '0;
  logic [31:0] wd = '0, rd, r, seed = 32'h153D9;
  logic [1:0]  rsp;
  int          mismatches = 0, total_checks = 0;
  wire logic [17:0] bus_addr_n;
  wire logic [12:0] word_index;
  wire logic [31:0] rdata;
  wire logic [1:0]  bus_ctl_n, bresp, rresp;
  wire logic        bus_dc_lo_n, bank_sel, byte_sel, xfer_read, test_mode, awr, wrd, bv, arr, rv;
  always #10 aclk = ~aclk;
  bad_bus_master_model i_bad_bus_master_model (.addr, .dc_lo, .wr, .bus_addr_n, .bus_dc_lo_n,
    .bus_ctl_n);
  // Straps are set low-true from the wanted bank number
  bad_decoder i_bad_decoder (.aclk, .aresetn, .bus_addr_n, .bus_dc_lo_n, .bus_ctl_n,
    .bank_strap_bit3(~bank_no[3]), .bank_strap_bit2(~bank_no[2]), .bank_strap_bit1(~bank_no[1]),
    .bank_strap_bit0(~bank_no[0]), .unused_slot_strap(uns), .test_strap(tst),
    .read_only_strap(ro), .bank_sel, .word_index, .byte_sel, .xfer_read, .test_mode,
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
    .s_axi_wvalid(wv), .s_axi_wready(wrd), .s_axi_wdata(wd), .s_axi_wstrb(4'hF),
    .s_axi_bvalid(bv), .s_axi_bready(bry), .s_axi_bresp(bresp), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_rvalid(rv),
    .s_axi_rready(rry), .s_axi_rdata(rdata), .s_axi_rresp(rresp));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Drive a logical address, then look once it has settled
  task automatic put(input logic [17:0] a);
    @(posedge aclk);
    addr <= a;
    @(negedge aclk);
  endtask
  // Write; both halves offered together, response taken with bready held
  task automatic axw(input logic [3:0] a, input logic [31:0] d);
    @(posedge aclk);
    {awaddr, wd, awv, wv, bry} <= {a, d, 3'h7};
    do begin
      @(posedge aclk);
      if (awr) awv <= '0;
      if (wrd) wv <= '0;
    end while (awv || wv);
    // No cycle count assumed; only the watchdog ends a hung wait
    while (bv !== 1'h1) @(posedge aclk);
    bry <= '0;
    rsp = bresp;
  endtask
  task automatic axr(input logic [3:0] a);
    @(posedge aclk);
    {araddr, arv, rry} <= {a, 2'h3};
    do begin
      @(posedge aclk);
      if (arr) arv <= '0;
    end while (rv !== 1'h1);
    rry <= '0;
    {rd, rsp} = {rdata, rresp};
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // Watchdog at 10000 cycles, far beyond the hundred or so cycles the tests take
  initial begin
    #200us;
    mismatches++;
    test_done();
  end
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'h1;
    // Every bank number: random hit, then a one-bit miss
    for (int b = 0; b < 16; b++) begin
      @(posedge aclk);
      bank_no <= b[3:0];
      r = rnd();
      put({b[3:0], r[13:0]});
      `CHK(bank_sel, 1'h1)
      @(negedge aclk);
      `CHK(({word_index, byte_sel}), r[13:0])
      put({b[3:0] ^ (4'h1 << r[17:16]), r[13:0]});
      `CHK(bank_sel, 1'h0)
    end
    put({bank_no, 14'h0});
    `CHK(bank_sel, 1'h1)
    $display("bank decode done");
    // Each disabling condition alone holds select low
    for (int k = 0; k < 3; k++) begin
      @(posedge aclk);
      {dc_lo, uns, tst} <= 3'h3 ^ (3'h4 >> k);
      @(negedge aclk);
      `CHK(bank_sel, 1'h0)
    end
    @(negedge aclk);
    `CHK(test_mode, 1'h1)
    // Read-only strap against both control levels
    for (int k = 0; k < 4; k++) begin
      @(posedge aclk);
      {tst, ro, wr} <= {1'h1, k[1:0]};
      @(posedge aclk);
      @(negedge aclk);
      `CHK(xfer_read, k[1] | !k[0])
    end
    $display("straps done");
    // Register bus: status, decode disable, capture of the select address
    axr(OFS_STATUS);
    `CHK(rd, ({24'h0, bank_no, uns, ro, 1'h0, 1'h1}))
    `CHK(rsp, RESP_OKAY)
    axw(OFS_CTRL, 32'h0);
    `CHK(rsp, RESP_OKAY)
    @(negedge aclk);
    `CHK(bank_sel, 1'h0)
    axw(OFS_CTRL, 32'h1);
    axr(OFS_LAST_ADR);
    `CHK(rd, ({14'h0, addr}))
    // Counter clear while selected, then one fresh rise
    axw(OFS_CTRL, 32'h3);
    axr(OFS_SEL_CNT);
    `CHK(rd, 32'h0)
    axw(OFS_CTRL, 32'h0);
    axw(OFS_CTRL, 32'h1);
    axr(OFS_SEL_CNT);
    `CHK(rd, 32'h1)
    // Unmapped offset answers with an error both ways
    axr(4'h2);
    `CHK(rsp, RESP_SLVERR)
    `CHK(rd, 32'h0)
    axw(4'h2, 32'h0);
    `CHK(rsp, RESP_SLVERR)
    $display("register bus done");
    // Mid-run reset brings decode enable back on
    axw(OFS_CTRL, 32'h0);
    @(posedge aclk);
    aresetn <= 1'h0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    @(negedge aclk);
    `CHK(bank_sel, 1'h1)
    axr(OFS_CTRL);
    `CHK(rd, 32'h1)
    $display("reset done");
    test_done();
  end
endmodule // bad_decoder_tb_top
